// [rtl/spc_pkg.sv]
package spc_pkg;

  // Register map, one byte per address
  localparam int ADDR_W = 3;
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_STAT = 3'h1;
  localparam logic [2:0] A_DATA = 3'h2;
  localparam logic [2:0] A_DDR = 3'h3;
  localparam logic [2:0] A_PORT = 3'h4;

  // serial_port_control bit positions
  localparam int CB_TIE = 0;
  localparam int CB_EN = 1;
  localparam int CB_WOM = 2;
  localparam int CB_CLOCK_PHASE = 3;
  localparam int CB_CLOCK_POLARITY = 4;
  localparam int CB_MSTR = 5;
  localparam int CB_RIE = 7;
  localparam logic [7:0] CTRL_MASK = 8'hBF;
  localparam logic [7:0] CTRL_RST = 8'h28;

  // serial_status_control bit positions
  localparam int SB_BAUD = 0;
  localparam int SB_MODE_FAULT_DETECT_ENABLE = 2;
  localparam int SB_TXE = 3;
  localparam int SB_MODE_FAULT_FLAG = 4;
  localparam int SB_OVRF = 5;
  localparam int SB_ERRIE = 6;
  localparam int SB_RXF = 7;

  // Shared port pin indices
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SS = 3;
  localparam int NUM_PINS = 4;
  localparam logic [3:0] PIN_RST = 4'h8;

  // Sixteen clock edges per byte, eight bits
  localparam logic [4:0] EDGE_LAST = 5'h0F;
  localparam int DIV_W_MIN = 7;

  // Baud divisors: half period of the serial clock in system clocks
  localparam logic [7:0] BD_0 = 8'h02;
  localparam logic [7:0] BD_1 = 8'h08;
  localparam logic [7:0] BD_2 = 8'h20;
  localparam logic [7:0] BD_3 = 8'h80;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } spc_st_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spc_bus_t;

  typedef struct packed {
    logic ss;
    logic sck;
    logic mosi;
    logic miso;
  } spc_pins_t;

  function automatic logic [7:0] spc_half_period(input logic [1:0] sel);
    case (sel)
      2'h0: spc_half_period = BD_0;
      2'h1: spc_half_period = BD_1;
      2'h2: spc_half_period = BD_2;
      default: spc_half_period = BD_3;
    endcase
  endfunction : spc_half_period

endpackage : spc_pkg

// [rtl/spc_top.sv]
`timescale 1ns/1ps
module spc_top
  import spc_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire spc_bus_t BUS,
  output logic [7:0] RDATA,
  input wire spc_pins_t PIN_I,
  output spc_pins_t PIN_O,
  output spc_pins_t PIN_OE,
  output logic PULLUP_EN,
  output logic TX_REQ,
  output logic RX_REQ,
  output logic ERR_REQ
);

  // Divider must hold the slowest half period
  if (DIV_W < DIV_W_MIN) begin : g_chk
    $error("DIV_W too narrow for the slowest baud divisor");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic err_ie;
    logic mode_fault_detect_enable;
    logic [1:0] baud;
    logic rx_full;
    logic ovrf;
    logic mode_fault_flag;
    logic tx_empty;
    logic rx_arm;
    logic ovr_arm;
    logic mode_fault_flag_arm;
    logic [7:0] tx_buf;
    logic [7:0] rx_data;
    logic [7:0] sr;
    logic ld;
    logic latch;
    logic [4:0] ecnt;
    spc_st_t st;
    logic sck_o;
    logic [DIV_W-1:0] div;
    logic [3:0] ddr;
    logic [3:0] pdat;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] flt;
    logic [7:0] rdata;
  } spc_state_t;

  spc_state_t q_ff;
  spc_state_t nxt_q;

  logic en;
  logic mst;
  logic clock_polarity;
  logic clock_phase;
  logic wom;
  logic ss_lvl;
  logic ss_used;
  logic mf_cond;
  logic sck_chg;
  logic ss_fall;
  logic div_last;
  logic din;
  logic edge_go;
  logic lead;
  logic done;
  logic load;
  logic [7:0] stat_rd;
  logic [3:0] port_rd;
  logic [3:0] spi_ctl;
  logic [3:0] spi_drv;
  logic [3:0] spi_val;
  logic [3:0] po;
  logic [3:0] poe;

  // Decoded configuration and filtered pin levels
  assign en = q_ff.ctrl[CB_EN];
  assign mst = q_ff.ctrl[CB_MSTR];
  assign clock_polarity = q_ff.ctrl[CB_CLOCK_POLARITY];
  assign clock_phase = q_ff.ctrl[CB_CLOCK_PHASE];
  assign wom = q_ff.ctrl[CB_WOM];
  assign ss_lvl = q_ff.flt[PIN_SS];
  assign ss_used = en & (~mst | q_ff.mode_fault_detect_enable);
  assign mf_cond = en & mst & q_ff.mode_fault_detect_enable & ~ss_lvl;
  // A change counts only once the second and third stages agree
  assign sck_chg = (q_ff.s2[PIN_SCK] == q_ff.s3[PIN_SCK]) &&
                   (q_ff.s3[PIN_SCK] != q_ff.flt[PIN_SCK]);
  assign ss_fall = (q_ff.s2[PIN_SS] == q_ff.s3[PIN_SS]) && !q_ff.s3[PIN_SS] &&
                   q_ff.flt[PIN_SS];
  assign div_last = (q_ff.div == DIV_W'(spc_half_period(q_ff.baud) - 8'h01));
  assign din = mst ? q_ff.flt[PIN_MISO] : q_ff.flt[PIN_MOSI];
  assign stat_rd = {q_ff.rx_full, q_ff.err_ie, q_ff.ovrf, q_ff.mode_fault_flag,
                    q_ff.tx_empty, q_ff.mode_fault_detect_enable, q_ff.baud};

  // Port data read: pin level for inputs, latch for outputs
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      port_rd[i] = q_ff.ddr[i] ? q_ff.pdat[i] : q_ff.flt[i];
    end
  end

  // Next state: synchroniser, register access, shift engine
  always_comb begin
    nxt_q = q_ff;
    edge_go = 1'b0;
    lead = 1'b0;
    done = 1'b0;
    load = 1'b0;
    nxt_q.s1 = PIN_I;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.flt[i] = q_ff.s3[i];
      end
    end
    // Read data stand only in the cycle after the strobe
    nxt_q.rdata = 8'h00;
    if (BUS.rd) begin
      case (BUS.addr)
        A_CTRL: nxt_q.rdata = q_ff.ctrl;
        A_STAT: begin
          nxt_q.rdata = stat_rd;
          nxt_q.rx_arm = q_ff.rx_full;
          nxt_q.ovr_arm = q_ff.ovrf;
          nxt_q.mode_fault_flag_arm = q_ff.mode_fault_flag;
        end
        A_DATA: begin
          nxt_q.rdata = q_ff.rx_data;
          if (q_ff.rx_arm) begin
            nxt_q.rx_full = 1'b0;
          end
          if (q_ff.ovr_arm) begin
            nxt_q.ovrf = 1'b0;
          end
          nxt_q.rx_arm = 1'b0;
          nxt_q.ovr_arm = 1'b0;
        end
        A_DDR: nxt_q.rdata = {4'h0, q_ff.ddr};
        A_PORT: nxt_q.rdata = {4'h0, port_rd};
        default: nxt_q.rdata = 8'h00;
      endcase
    end
    if (BUS.wr) begin
      case (BUS.addr)
        A_CTRL: begin
          nxt_q.ctrl = BUS.wdata & CTRL_MASK;
          // Fault clears only while no fault condition persists
          if (q_ff.mode_fault_flag_arm && !mf_cond) begin
            nxt_q.mode_fault_flag = 1'b0;
          end
          nxt_q.mode_fault_flag_arm = 1'b0;
        end
        A_STAT: begin
          nxt_q.err_ie = BUS.wdata[SB_ERRIE];
          nxt_q.mode_fault_detect_enable = BUS.wdata[SB_MODE_FAULT_DETECT_ENABLE];
          nxt_q.baud = BUS.wdata[SB_BAUD +: 2];
        end
        A_DATA: begin
          nxt_q.tx_buf = BUS.wdata;
          nxt_q.tx_empty = 1'b0;
        end
        A_DDR: nxt_q.ddr = BUS.wdata[3:0];
        A_PORT: nxt_q.pdat = BUS.wdata[3:0];
        default: nxt_q.ctrl = q_ff.ctrl;
      endcase
    end
    if (!en) begin
      // Partial reset; control bits and rx flags survive
      nxt_q.tx_empty = 1'b1;
      nxt_q.st = ST_IDLE;
      nxt_q.ecnt = 5'h00;
      nxt_q.sr = 8'h00;
      nxt_q.ld = 1'b0;
      nxt_q.div = '0;
      nxt_q.sck_o = clock_polarity;
    end else begin
      // Transmit buffer moves into the idle shift register
      if (q_ff.st == ST_IDLE && !q_ff.tx_empty) begin
        load = 1'b1;
        nxt_q.sr = q_ff.tx_buf;
        nxt_q.ld = 1'b1;
        nxt_q.tx_empty = 1'b1;
      end
      if (mst) begin
        if (q_ff.st == ST_IDLE) begin
          nxt_q.sck_o = clock_polarity;
          nxt_q.div = '0;
          if (q_ff.ld) begin
            nxt_q.st = ST_RUN;
          end
        end else if (div_last) begin
          nxt_q.div = '0;
          nxt_q.sck_o = ~q_ff.sck_o;
          edge_go = 1'b1;
          lead = (q_ff.sck_o == clock_polarity);
        end else begin
          nxt_q.div = q_ff.div + DIV_W'(1);
        end
        // Another master pulled select low: drop off the bus
        if (mf_cond) begin
          nxt_q.mode_fault_flag = 1'b1;
          nxt_q.ctrl[CB_EN] = 1'b0;
        end
      end else if (ss_lvl) begin
        // Deselected slave drops any partial byte and its clocks
        if (q_ff.st == ST_RUN && q_ff.mode_fault_detect_enable) begin
          nxt_q.mode_fault_flag = 1'b1;
        end
        nxt_q.st = ST_IDLE;
        nxt_q.ecnt = 5'h00;
      end else begin
        if (!clock_phase && ss_fall) begin
          nxt_q.st = ST_RUN;
        end
        if (sck_chg) begin
          lead = (q_ff.s3[PIN_SCK] != clock_polarity);
          if (q_ff.st == ST_RUN || (clock_phase && lead)) begin
            edge_go = 1'b1;
            nxt_q.st = ST_RUN;
          end
        end
      end
      // Shared edge handling: sample on one edge, shift on the other
      if (edge_go) begin
        nxt_q.ecnt = q_ff.ecnt + 5'h01;
        if (lead ^ clock_phase) begin
          nxt_q.latch = din;
        end else if (q_ff.ecnt != 5'h00) begin
          nxt_q.sr = {q_ff.sr[6:0], q_ff.latch};
        end
        if (q_ff.ecnt == EDGE_LAST) begin
          done = 1'b1;
          nxt_q.st = ST_IDLE;
          nxt_q.ecnt = 5'h00;
          nxt_q.ld = 1'b0;
          // Overrun keeps the old byte; a same-cycle read clear lets it land
          if (nxt_q.rx_full) begin
            nxt_q.ovrf = 1'b1;
          end else begin
            nxt_q.rx_data = {q_ff.sr[6:0], clock_phase ? din : q_ff.latch};
            nxt_q.rx_full = 1'b1;
          end
        end
      end
    end
  end

  // Register the whole state
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q_ff <= '0;
      q_ff.ctrl <= CTRL_RST;
      q_ff.tx_empty <= 1'b1;
      q_ff.s1 <= PIN_RST;
      q_ff.s2 <= PIN_RST;
      q_ff.s3 <= PIN_RST;
      q_ff.flt <= PIN_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Which pins the serial logic owns, drives and with what
  assign spi_ctl = {ss_used, en, en, en};
  assign spi_drv = {1'b0, en & mst, en & mst, en & ~mst & ~ss_lvl};
  assign spi_val = {1'b0, q_ff.sck_o, q_ff.sr[7], q_ff.sr[7]};

  // Per-pin mux; open drain only ever pulls low
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    if (g == PIN_SS) begin : g_ss
      assign po[g] = q_ff.pdat[g];
      assign poe[g] = spi_ctl[g] ? 1'b0 : q_ff.ddr[g];
    end else begin : g_ser
      assign po[g] = spi_ctl[g] ? (wom ? 1'b0 : spi_val[g]) : q_ff.pdat[g];
      assign poe[g] = spi_ctl[g] ? (spi_drv[g] & (~wom | ~spi_val[g]))
                                 : q_ff.ddr[g];
    end
  end

  assign PIN_O = po;
  assign PIN_OE = poe;
  assign PULLUP_EN = ~wom;
  assign RDATA = q_ff.rdata;
  assign TX_REQ = q_ff.tx_empty & q_ff.ctrl[CB_TIE] & en;
  assign RX_REQ = q_ff.rx_full & q_ff.ctrl[CB_RIE];
  assign ERR_REQ = (q_ff.mode_fault_flag | q_ff.ovrf) & q_ff.err_ie;

  // Checks on the pin ownership and flag behaviour
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_slave_break;
    q_ff.st == ST_RUN && en && !mst && q_ff.mode_fault_detect_enable ##1 ss_lvl;
  endsequence
  sequence s_byte_done;
    done && !q_ff.rx_full;
  endsequence

  property p_miso_slave_only;
    poe[PIN_MISO] && en |-> !mst && !ss_lvl;
  endproperty
  a_miso_slave_only: assert property (p_miso_slave_only)
    else $error("MISO driven while not a selected slave");

  property p_miso_float;
    en && !mst && ss_lvl |-> !PIN_OE.miso;
  endproperty
  a_miso_float: assert property (p_miso_float)
    else $error("MISO not floating with slave deselected");

  property p_slave_ignore;
    en && !mst && ss_lvl |=> q_ff.ecnt == 5'h00 && q_ff.st == ST_IDLE;
  endproperty
  a_slave_ignore: assert property (p_slave_ignore)
    else $error("Deselected slave still counting edges");

  property p_slave_inputs;
    en && !mst |-> !PIN_OE.sck && !PIN_OE.mosi && !PIN_OE.ss;
  endproperty
  a_slave_inputs: assert property (p_slave_inputs)
    else $error("Slave drives clock, MOSI or select");

  // Byte that the last edge is about to complete
  logic [7:0] rx_q_shadow;
  assign rx_q_shadow = {q_ff.sr[6:0], clock_phase ? din : q_ff.latch};
  property p_rx_set;
    s_byte_done |=> q_ff.rx_full ##0 $past(rx_q_shadow) == q_ff.rx_data;
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("Completed byte did not reach receive data");

  property p_load_empty;
    load |=> q_ff.tx_empty && q_ff.sr == $past(q_ff.tx_buf);
  endproperty
  a_load_empty: assert property (p_load_empty)
    else $error("Load did not set transmit-empty");

  property p_disable;
    !en |=> q_ff.tx_empty && q_ff.ecnt == 5'h00 && q_ff.sr == 8'h00;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Partial reset incomplete");

  property p_master_fault;
    mf_cond |=> q_ff.mode_fault_flag && !en ##1 poe[PIN_SCK] == q_ff.ddr[PIN_SCK];
  endproperty
  a_master_fault: assert property (p_master_fault)
    else $error("Master fault not raised or not disabling");

  property p_fault_needs_en;
    $rose(q_ff.mode_fault_flag) |-> $past(q_ff.mode_fault_detect_enable);
  endproperty
  a_fault_needs_en: assert property (p_fault_needs_en)
    else $error("Mode fault without detect enable");

  property p_slave_fault;
    s_slave_break |=> q_ff.mode_fault_flag;
  endproperty
  a_slave_fault: assert property (p_slave_fault)
    else $error("Slave fault missed on select rise");

  property p_ss_gpio;
    !ss_used |-> PIN_OE.ss == q_ff.ddr[PIN_SS];
  endproperty
  a_ss_gpio: assert property (p_ss_gpio)
    else $error("Select pin not under port direction");

  property p_rx_req;
    $rose(q_ff.rx_full) && q_ff.ctrl[CB_RIE] |-> RX_REQ;
  endproperty
  a_rx_req: assert property (p_rx_req)
    else $error("Receive request not raised");

endmodule : spc_top

// [dv/spc_slave_model.sv]
`timescale 1ns/1ps
// Far-end slave: clock idles low, shifts on leading edge, samples on trailing
module spc_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int cnt;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    cnt = 0;
  end

  // Released line shows the inverse, so a stale bit never passes
  always @(posedge ss_n) begin
    cnt = 0;
    miso = ~miso;
  end

  // Same polarity and phase as the block under test
  always @(posedge sck) begin
    if (!ss_n && cnt < 8) begin
      miso = tx_byte[7 - cnt];
    end
  end

  // Capture on trailing edge, MSB first
  always @(negedge sck) begin
    if (!ss_n) begin
      rx_byte = {rx_byte[6:0], mosi};
      cnt = cnt + 1;
    end
  end
endmodule : spc_slave_model

// [dv/spc_top_tb.sv]
`timescale 1ns/1ps
module spc_top_tb;
  import spc_pkg::*;
  logic clk, rst_n, pullup_en, tx_req, rx_req, err_req;
  logic tb_ss, tb_sck, tb_mosi, part_ss_n, part_miso;
  logic [7:0] rdata, part_tx, part_rx, d;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  spc_bus_t bus;
  spc_pins_t pin_i, pin_o, pin_oe;
  int err_count, comparisons, cyc;

  spc_top #(.DIV_W(7)) uut (.CLOCK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PULLUP_EN(pullup_en),
    .TX_REQ(tx_req), .RX_REQ(rx_req), .ERR_REQ(err_req));
  spc_slave_model partner (.sck(pin_i.sck), .mosi(pin_i.mosi), .ss_n(part_ss_n),
    .tx_byte(part_tx), .miso(part_miso), .rx_byte(part_rx));

  // Each wire takes the block's level while it drives, else the far side's
  always_comb begin
    pin_i.ss = pin_oe.ss ? pin_o.ss : tb_ss;
    pin_i.sck = pin_oe.sck ? pin_o.sck : tb_sck;
    pin_i.mosi = pin_oe.mosi ? pin_o.mosi : tb_mosi;
    pin_i.miso = pin_oe.miso ? pin_o.miso : part_miso;
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    $display("Errors %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    // Let the written state settle before any pin check
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask : rchk

  // Poll status under a bound until a byte has arrived
  task automatic wait_rx();
    d = 8'h00;
    for (int i = 0; i < 300 && d[SB_RXF] !== 1'b1; i++) begin
      rd(A_STAT, d);
    end
  endtask : wait_rx

  // Bench as link master: 800 ns clock only inside the frame
  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tb_sck <= 1'b1;
      tb_mosi <= v[7 - i];
      repeat (4) @(posedge clk);
      tb_sck <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : send_bits

  initial begin
    {rst_n, tb_sck, tb_mosi} = 3'h0;
    {tb_ss, part_ss_n} = 2'h3;
    bus = '0;
    part_tx = 8'h00;
    seed = 32'd11027;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_CTRL, CTRL_RST);
    rchk(A_STAT, 8'h08);
    rchk(3'h5, 8'h00);
    chk({4'h0, pin_oe}, 8'h00);
    chk({6'h00, pullup_en, tx_req}, 8'h02);
    wr(A_CTRL, 8'hFF);
    rchk(A_CTRL, 8'hBF);
    wr(A_CTRL, CTRL_RST);
    // Disabled port: pins follow the shared port, select pin readable
    wr(A_DDR, 8'h07);
    wr(A_PORT, 8'h05);
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk);
    chk({pin_oe, pin_o}, 8'h75);
    rchk(A_PORT, 8'h05);
    tb_ss <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(A_PORT, 8'h0D);
    // Enabled master overrides direction on data and clock pins
    wr(A_STAT, 8'h01);
    wr(A_CTRL, 8'h2B);
    chk({4'h0, pin_oe}, 8'h06);
    chk({7'h00, tx_req}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(A_CTRL, (k == 0) ? 8'hAB : 8'h2B);
      seed = xs(seed);
      part_tx = seed[15:8];
      exp_q.push_back(seed[7:0]);
      part_ss_n <= 1'b0;
      wr(A_DATA, seed[7:0]);
      wait_rx();
      chk({7'h00, d[SB_RXF]}, 8'h01);
      chk({6'h00, rx_req, tx_req}, (k == 0) ? 8'h03 : 8'h01);
      rchk(A_DATA, part_tx);
      chk(part_rx, exp_q.pop_front());
      part_ss_n <= 1'b1;
    end
    wr(A_CTRL, 8'h2F);
    chk({7'h00, pullup_en}, 8'h00);
    wr(A_CTRL, 8'h2B);
    // Master select fault: ignored without detect, then taken
    wr(A_DDR, 8'h0F);
    tb_ss <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(A_STAT, 8'h09);
    wr(A_STAT, 8'h05);
    chk({4'h0, pin_oe}, 8'h06);
    repeat (8) @(posedge clk);
    rchk(A_STAT, 8'h1D);
    rchk(A_CTRL, 8'h29);
    chk({4'h0, pin_oe}, 8'h0F);
    wr(A_DDR, 8'h07);
    tb_ss <= 1'b1;
    repeat (8) @(posedge clk);
    wr(A_CTRL, 8'h28);
    rchk(A_STAT, 8'h0D);
    // Slave: select gates the data output and the incoming clock
    wr(A_STAT, 8'h00);
    wr(A_CTRL, 8'h0A);
    repeat (6) @(posedge clk);
    chk({4'h0, pin_oe}, 8'h00);
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk);
    chk({4'h0, pin_oe}, 8'h01);
    seed = xs(seed);
    send_bits(seed[7:0], 4);
    tb_ss <= 1'b1;
    repeat (8) @(posedge clk);
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk);
    exp_q.push_back(seed[15:8]);
    send_bits(seed[15:8], 8);
    wait_rx();
    rchk(A_DATA, exp_q.pop_front());
    print_verdict();
  end
endmodule : spc_top_tb
